//--- hdl/drdc_pkg.sv
package drdc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_BASE_LO = 8'h04;
  localparam logic [7:0] OFS_BASE_HI = 8'h08;
  localparam logic [7:0] OFS_RING    = 8'h0C;
  localparam logic [7:0] OFS_PFLIM   = 8'h10;
  localparam logic [7:0] OFS_OWN     = 8'h14;
  localparam logic [7:0] OFS_CUR     = 8'h18;
  localparam logic [7:0] OFS_XCNT    = 8'h1C;
  localparam logic [7:0] OFS_MAXSZ   = 8'h20;

  // Control/status bit positions and max payload size field position
  localparam int CB_START       = 0;
  localparam int CB_HALT        = 1;
  localparam int CB_CANCEL      = 2;
  localparam int CB_MODE64      = 3;
  localparam int CB_BRIDGE      = 4;
  localparam int CB_UPPEER      = 5;
  localparam int CB_HALT_DONE   = 8;
  localparam int CB_CANCEL_DONE = 9;
  localparam int CB_BUSY        = 10;
  localparam int MS_MPS_LSB     = 16;

  // Descriptor control byte bits
  localparam int DC_FINAL = 7;
  localparam int DC_IRQ   = 6;
  localparam int DC_SRCV  = 4;
  localparam int DC_DSTV  = 3;

  // Sizes
  localparam int IDX_W      = 5;
  localparam int RING_MAX   = 32;
  localparam int FIFO_DEPTH = 12;
  localparam int FIFO_CW    = 4;
  localparam logic [5:0] FIFO_CAP32 = 6'h0C;
  localparam logic [5:0] FIFO_CAP64 = 6'h08;
  localparam logic [4:0] DESC_B64   = 5'h14;
  localparam logic [4:0] DESC_B32   = 5'h0C;
  localparam logic [63:0] SIZE_OFS64 = 64'h0000000000000010;
  localparam logic [63:0] SIZE_OFS32 = 64'h0000000000000008;
  localparam logic [12:0] PAGE_BYTES = 13'h1000;
  localparam logic [12:0] LEN_MAX    = 13'h1FFF;

  // Reset values
  localparam logic [5:0]  RING_RST  = 6'h20;
  localparam logic [5:0]  PFLIM_RST = 6'h08;
  localparam logic [12:0] MRS_RST   = 13'h0200;
  localparam logic [12:0] MPS_RST   = 13'h0080;

  typedef struct packed {
    logic [4:0]  idx;
    logic [7:0]  ctrl;
    logic [23:0] size;
    logic [63:0] dst;
    logic [63:0] src;
  } drdc_desc_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_LOAD   = 3'h1,
    ST_REQ    = 3'h3,
    ST_CPL    = 3'h2,
    ST_FIN    = 3'h6,
    ST_WB     = 3'h7,
    ST_HALT   = 3'h5,
    ST_CANCEL = 3'h4
  } drdc_state_t;

endpackage

//--- hdl/drdc_desc_fifo.sv
`timescale 1ns/10ps
module drdc_desc_fifo #(
  parameter int WIDTH = $bits(drdc_pkg::drdc_desc_t),
  parameter int DEPTH = drdc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset,
  // Control
  input  wire logic                            flush,
  input  wire logic                            push,
  input  wire logic [WIDTH-1:0]                push_data,
  input  wire logic                            pop,
  // Status and data
  output logic      [WIDTH-1:0]                pop_data,
  output logic      [drdc_pkg::FIFO_CW-1:0]    count
);

  localparam logic [drdc_pkg::FIFO_CW-1:0] PTR_LAST = drdc_pkg::FIFO_CW'(DEPTH - 1);

  logic [WIDTH-1:0]             mem [DEPTH];
  logic [drdc_pkg::FIFO_CW-1:0] wp_reg;
  logic [drdc_pkg::FIFO_CW-1:0] rp_reg;

  wire [drdc_pkg::FIFO_CW-1:0] wp_next = (wp_reg == PTR_LAST) ? '0 : wp_reg + 1'b1;
  wire [drdc_pkg::FIFO_CW-1:0] rp_next = (rp_reg == PTR_LAST) ? '0 : rp_reg + 1'b1;

  always_ff @(posedge clk_sys) begin
    if (reset || flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count  <= '0;
    end else begin
      if (push) wp_reg <= wp_next;
      if (pop) rp_reg <= rp_next;
      count <= count + {3'h0, push} - {3'h0, pop};
    end
  end

  // Storage has no reset to stay a plain RAM
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_reg] <= push_data;
    if (pop) pop_data <= mem[rp_reg];
  end

endmodule

//--- hdl/drdc_channel.sv
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module drdc_channel (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Descriptor fetch
  output logic             dreq_valid,
  output logic      [63:0] dreq_addr,
  output logic      [5:0]  dreq_cnt,
  input  wire logic        dreq_ready,
  input  wire logic        drx_valid,
  input  wire logic [63:0] drx_src,
  input  wire logic [63:0] drx_dst,
  input  wire logic [23:0] drx_size,
  input  wire logic [7:0]  drx_ctrl,
  // Data reads and completions
  output logic             rd_valid,
  output logic      [63:0] rd_addr,
  output logic      [12:0] rd_len,
  input  wire logic        rd_ready,
  output logic             rd_flush,
  input  wire logic        cpl_valid,
  input  wire logic [31:0] cpl_data,
  input  wire logic        cpl_last,
  // Posted writes
  output logic             wr_valid,
  output logic      [63:0] wr_addr,
  output logic      [31:0] wr_data,
  output logic             wr_last,
  // Descriptor write-back
  output logic             dwb_valid,
  output logic      [63:0] dwb_addr,
  output logic      [23:0] dwb_size,
  output logic      [7:0]  dwb_ctrl,
  input  wire logic        dwb_ready,
  // Paired engine link
  input  wire logic [63:0] peer_ptr_i,
  output logic      [63:0] peer_ptr_o,
  output logic             peer_adv_o,
  input  wire logic        peer_adv_i,
  output logic             peer_final_o,
  output logic      [23:0] peer_count_o,
  input  wire logic        peer_final_i,
  input  wire logic [23:0] peer_count_i,
  // Events
  output logic             desc_irq,
  output logic             halt_irq
);

  drdc_pkg::drdc_state_t state_reg, state_next;
  drdc_pkg::drdc_desc_t  push_d, pop_d;

  logic        start_reg, start_q_reg, halt_req_reg, cancel_req_reg;
  logic        mode64_reg, bridge_reg, uppeer_reg, halt_done_reg, cancel_done_reg;
  logic [63:0] base_reg;
  logic [5:0]  ring_reg, pflim_reg;
  logic [12:0] mrs_reg, mps_reg;
  logic [31:0] own_reg, fetched_reg;
  logic [4:0]  cur_reg, fidx_reg, rx_idx_reg;
  logic [5:0]  fetch_left_reg;
  logic        drop_reg, pfin_reg;
  logic [23:0] xcnt_reg, rem_reg, moved_reg, pcnt_reg;
  logic [63:0] src_reg, dst_reg;
  logic [7:0]  dctl_reg;
  logic [12:0] chunk_reg;
  logic [3:0]  fifo_count;
  logic [5:0]  run;
  logic [31:0] run_mask;
  logic [31:0] ctrl_rd;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr  = bus_req & wb_we_i & (&wb_sel_i);
  wire wr_ctrl = bus_wr & (wb_adr_i == drdc_pkg::OFS_CTRL);
  wire wr_own  = bus_wr & (wb_adr_i == drdc_pkg::OFS_OWN);
  wire cfg_ok  = bus_wr & ~start_reg;
  wire wr_blo  = cfg_ok & (wb_adr_i == drdc_pkg::OFS_BASE_LO);
  wire wr_bhi  = cfg_ok & (wb_adr_i == drdc_pkg::OFS_BASE_HI);
  wire wr_ring = cfg_ok & (wb_adr_i == drdc_pkg::OFS_RING);
  wire wr_pfl  = bus_wr & (wb_adr_i == drdc_pkg::OFS_PFLIM);
  wire wr_msz  = bus_wr & (wb_adr_i == drdc_pkg::OFS_MAXSZ);

  // Channel events
  wire stop_evt   = start_q_reg & ~start_reg;
  wire cancel_hit = cancel_req_reg & ~cancel_done_reg;
  wire cancel_ent = cancel_hit & (state_reg != drdc_pkg::ST_CANCEL) & ~stop_evt;
  wire free_all   = stop_evt | cancel_ent;
  wire running    = start_reg & ~cancel_req_reg & ~cancel_done_reg;
  wire fin        = (state_reg == drdc_pkg::ST_FIN);
  wire is_final   = dctl_reg[drdc_pkg::DC_FINAL];
  wire halt_ent   = (state_reg == drdc_pkg::ST_IDLE) & (state_next == drdc_pkg::ST_HALT);
  wire need_wb    = (is_final & ~bridge_reg & ~uppeer_reg) | (uppeer_reg & pfin_reg);

  wire [5:0]  cap   = mode64_reg ? drdc_pkg::FIFO_CAP64 : drdc_pkg::FIFO_CAP32;
  wire [5:0]  lim   = (pflim_reg < cap) ? pflim_reg : cap;
  wire [5:0]  ahead = {2'h0, fifo_count} + fetch_left_reg;
  wire [5:0]  space = (lim > ahead) ? lim - ahead : 6'h00;
  wire [4:0]  dbyte = mode64_reg ? drdc_pkg::DESC_B64 : drdc_pkg::DESC_B32;
  wire [63:0] soff  = mode64_reg ? drdc_pkg::SIZE_OFS64 : drdc_pkg::SIZE_OFS32;
  wire [5:0]  fnext = {1'b0, fidx_reg} + run;
  wire [5:0]  cnext = {1'b0, cur_reg} + 6'h01;
  wire [31:0] cur_bit = 32'h00000001 << cur_reg;

  // prefetch only while owned descriptors wait
  wire pf_go = running & ~halt_req_reg & ~halt_done_reg & ~drop_reg & ~dreq_valid
             & (fetch_left_reg == 6'h00) & (run != 6'h00);

  // burst stops at ring end; bounded by space
  always_comb begin
    logic [5:0] ix;
    logic       stop;
    ix       = '0;
    stop     = 1'b0;
    run      = '0;
    run_mask = '0;
    for (int i = 0; i < drdc_pkg::RING_MAX; i++) begin
      ix = {1'b0, fidx_reg} + 6'(i);
      if (!stop && ix < ring_reg && 6'(i) < space
          && own_reg[ix[4:0]] && !fetched_reg[ix[4:0]]) begin
        run = run + 6'h01;
        run_mask[ix[4:0]] = 1'b1;
      end else begin
        stop = 1'b1;
      end
    end
  end

  // chunk limited by read size, payload and 4K pages
  wire [12:0] to_ps = drdc_pkg::PAGE_BYTES - {1'b0, src_reg[11:0]};
  wire [12:0] to_pd = drdc_pkg::PAGE_BYTES - {1'b0, dst_reg[11:0]};
  wire [12:0] rem13 = (rem_reg > {11'h000, drdc_pkg::LEN_MAX}) ? drdc_pkg::LEN_MAX
                    : rem_reg[12:0];
  wire [12:0] m_a   = (mrs_reg < mps_reg) ? mrs_reg : mps_reg;
  wire [12:0] m_b   = (to_ps < to_pd) ? to_ps : to_pd;
  wire [12:0] m_c   = (m_a < m_b) ? m_a : m_b;
  wire [12:0] chunk = (rem13 < m_c) ? rem13 : m_c;

  // bridge side takes peer pointer as dst if source valid, else as src; direction from source valid bit
  wire        srcv  = pop_d.ctrl[drdc_pkg::DC_SRCV];
  wire [63:0] ld_src = (bridge_reg & ~srcv) ? peer_ptr_i : pop_d.src;
  wire [63:0] ld_dst = (bridge_reg & srcv) ? peer_ptr_i : pop_d.dst;

  wire fifo_pop  = (state_reg == drdc_pkg::ST_IDLE) & (state_next == drdc_pkg::ST_LOAD);
  wire fifo_push = drx_valid & ~drop_reg & running;

  assign push_d = '{idx: rx_idx_reg, ctrl: drx_ctrl, size: drx_size, dst: drx_dst,
                    src: drx_src};

  drdc_desc_fifo u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .flush     (free_all),
    .push      (fifo_push),
    .push_data (push_d),
    .pop       (fifo_pop),
    .pop_data  (pop_d),
    .count     (fifo_count)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      drdc_pkg::ST_IDLE: begin
        if (cancel_hit) state_next = drdc_pkg::ST_CANCEL;
        else if (pfin_reg && !dwb_valid) state_next = drdc_pkg::ST_WB;
        else if (running && halt_req_reg) begin
          if (fetch_left_reg == 6'h00 && !dreq_valid) state_next = drdc_pkg::ST_HALT;
        end else if (running && fifo_count != 4'h0) state_next = drdc_pkg::ST_LOAD;
      end
      drdc_pkg::ST_LOAD:
        state_next = (pop_d.size == 24'h000000) ? drdc_pkg::ST_FIN : drdc_pkg::ST_REQ;
      drdc_pkg::ST_REQ: begin
        if (cancel_hit) state_next = drdc_pkg::ST_CANCEL;
        else if (uppeer_reg) begin
          if (peer_adv_i) state_next = drdc_pkg::ST_FIN;
        end else if (rd_valid && rd_ready) state_next = drdc_pkg::ST_CPL;
      end
      drdc_pkg::ST_CPL: begin
        if (cancel_hit) state_next = drdc_pkg::ST_CANCEL;
        else if (cpl_valid && cpl_last)
          state_next = (rem_reg == {11'h000, chunk_reg}) ? drdc_pkg::ST_FIN
                     : drdc_pkg::ST_REQ;
      end
      drdc_pkg::ST_FIN:
        state_next = need_wb ? drdc_pkg::ST_WB : drdc_pkg::ST_IDLE;
      drdc_pkg::ST_WB:
        if (dwb_valid && dwb_ready) state_next = drdc_pkg::ST_IDLE;
      // resume once both halt bits are clear
      drdc_pkg::ST_HALT: begin
        if (cancel_hit) state_next = drdc_pkg::ST_CANCEL;
        else if (!halt_req_reg && !halt_done_reg) state_next = drdc_pkg::ST_IDLE;
      end
      drdc_pkg::ST_CANCEL:
        if (!cancel_req_reg && !cancel_done_reg) state_next = drdc_pkg::ST_IDLE;
      default: state_next = drdc_pkg::ST_IDLE;
    endcase
    if (stop_evt) state_next = drdc_pkg::ST_IDLE;
  end

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[drdc_pkg::CB_START]       = start_reg;
    ctrl_rd[drdc_pkg::CB_HALT]        = halt_req_reg;
    ctrl_rd[drdc_pkg::CB_CANCEL]      = cancel_req_reg;
    ctrl_rd[drdc_pkg::CB_MODE64]      = mode64_reg;
    ctrl_rd[drdc_pkg::CB_BRIDGE]      = bridge_reg;
    ctrl_rd[drdc_pkg::CB_UPPEER]      = uppeer_reg;
    ctrl_rd[drdc_pkg::CB_HALT_DONE]   = halt_done_reg;
    ctrl_rd[drdc_pkg::CB_CANCEL_DONE] = cancel_done_reg;
    ctrl_rd[drdc_pkg::CB_BUSY]        = (state_reg != drdc_pkg::ST_IDLE);
  end

  wire [31:0] rd_mux =
      (wb_adr_i == drdc_pkg::OFS_CTRL)    ? ctrl_rd :
      (wb_adr_i == drdc_pkg::OFS_BASE_LO) ? base_reg[31:0] :
      (wb_adr_i == drdc_pkg::OFS_BASE_HI) ? base_reg[63:32] :
      (wb_adr_i == drdc_pkg::OFS_RING)    ? {26'h0, ring_reg} :
      (wb_adr_i == drdc_pkg::OFS_PFLIM)   ? {26'h0, pflim_reg} :
      (wb_adr_i == drdc_pkg::OFS_OWN)     ? own_reg :
      (wb_adr_i == drdc_pkg::OFS_CUR)     ? {27'h0, cur_reg} :
      (wb_adr_i == drdc_pkg::OFS_XCNT)    ? {8'h00, xcnt_reg} :
      (wb_adr_i == drdc_pkg::OFS_MAXSZ)   ? {3'h0, mps_reg, 3'h0, mrs_reg} : 32'h0;

  // Register file and control flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0; wb_dat_o <= '0;
      start_reg <= 1'b0; start_q_reg <= 1'b0; halt_req_reg <= 1'b0;
      cancel_req_reg <= 1'b0; mode64_reg <= 1'b0; bridge_reg <= 1'b0;
      uppeer_reg <= 1'b0; halt_done_reg <= 1'b0; cancel_done_reg <= 1'b0;
      base_reg <= '0; ring_reg <= drdc_pkg::RING_RST; pflim_reg <= drdc_pkg::PFLIM_RST;
      mrs_reg <= drdc_pkg::MRS_RST; mps_reg <= drdc_pkg::MPS_RST; own_reg <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) wb_dat_o <= rd_mux;
      start_q_reg <= start_reg;
      if (wr_ctrl) begin
        start_reg      <= wb_dat_i[drdc_pkg::CB_START];
        halt_req_reg   <= wb_dat_i[drdc_pkg::CB_HALT];
        cancel_req_reg <= wb_dat_i[drdc_pkg::CB_CANCEL];
        if (!start_reg) begin
          mode64_reg <= wb_dat_i[drdc_pkg::CB_MODE64];
          bridge_reg <= wb_dat_i[drdc_pkg::CB_BRIDGE];
          uppeer_reg <= wb_dat_i[drdc_pkg::CB_UPPEER];
        end
      end
      halt_done_reg <= halt_ent
                     | (halt_done_reg & ~(wr_ctrl & ~wb_dat_i[drdc_pkg::CB_HALT_DONE]));
      cancel_done_reg <= cancel_ent
                       | (cancel_done_reg & ~(wr_ctrl & ~wb_dat_i[drdc_pkg::CB_CANCEL_DONE]));
      if (wr_blo) base_reg[31:0] <= wb_dat_i;
      if (wr_bhi) base_reg[63:32] <= wb_dat_i;
      if (wr_ring) ring_reg <= wb_dat_i[5:0];
      if (wr_pfl) pflim_reg <= wb_dat_i[5:0];
      if (wr_msz) begin
        mrs_reg <= wb_dat_i[12:0];
        mps_reg <= wb_dat_i[drdc_pkg::MS_MPS_LSB +: 13];
      end
      // software set and hardware clear both survive; free all
      if (free_all) own_reg <= wr_own ? wb_dat_i : '0;
      // finish clears ownership; software writes ones
      else own_reg <= (own_reg & ~(fin ? cur_bit : 32'h0)) | (wr_own ? wb_dat_i : 32'h0);
    end
  end

  // Prefetch engine
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dreq_valid <= 1'b0; dreq_addr <= '0; dreq_cnt <= '0;
      fidx_reg <= '0; rx_idx_reg <= '0; fetch_left_reg <= '0;
      fetched_reg <= '0; drop_reg <= 1'b0;
    end else begin
      if (dreq_valid && dreq_ready) dreq_valid <= 1'b0;
      if (pf_go) begin
        dreq_valid     <= 1'b1;
        dreq_addr      <= base_reg + 64'(fidx_reg) * 64'(dbyte);
        dreq_cnt       <= run;
        rx_idx_reg     <= fidx_reg;
        fetch_left_reg <= run;
        fidx_reg       <= (fnext >= ring_reg) ? 5'h00 : fnext[4:0];
      end else if (drx_valid && fetch_left_reg != 6'h00) begin
        fetch_left_reg <= fetch_left_reg - 6'h01;
        rx_idx_reg     <= rx_idx_reg + 5'h01;
      end
      // returns after cancel or stop are discarded
      if (free_all) drop_reg <= 1'b1;
      else if (fetch_left_reg == 6'h00) drop_reg <= 1'b0;
      if (free_all) fetched_reg <= '0;
      else fetched_reg <= (fetched_reg & ~(fin ? cur_bit : 32'h0))
                        | (pf_go ? run_mask : 32'h0);
      // cancel resumes at current pointer; stop reloads base
      if (stop_evt) fidx_reg <= '0;
      else if (cancel_ent) fidx_reg <= cur_reg;
    end
  end

  // Descriptor processing datapath
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= drdc_pkg::ST_IDLE; cur_reg <= '0; xcnt_reg <= '0;
      rem_reg <= '0; moved_reg <= '0; src_reg <= '0; dst_reg <= '0;
      dctl_reg <= '0; chunk_reg <= '0; pfin_reg <= 1'b0; pcnt_reg <= '0;
      rd_valid <= 1'b0; rd_addr <= '0; rd_len <= '0; rd_flush <= 1'b0;
      wr_valid <= 1'b0; wr_addr <= '0; wr_data <= '0; wr_last <= 1'b0;
      dwb_valid <= 1'b0; dwb_addr <= '0; dwb_size <= '0; dwb_ctrl <= '0;
      peer_ptr_o <= '0; peer_adv_o <= 1'b0; peer_final_o <= 1'b0;
      peer_count_o <= '0; desc_irq <= 1'b0; halt_irq <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rd_flush     <= free_all;
      halt_irq     <= halt_ent;
      desc_irq     <= 1'b0;
      peer_adv_o   <= 1'b0;
      peer_final_o <= 1'b0;
      wr_valid     <= 1'b0;
      wr_last      <= 1'b0;
      // peer final noted for write-back into own descriptor
      if (uppeer_reg && peer_final_i && !free_all) begin
        pfin_reg <= 1'b1;
        pcnt_reg <= peer_count_i;
      end
      if (state_reg == drdc_pkg::ST_LOAD) begin
        src_reg <= ld_src; dst_reg <= ld_dst; rem_reg <= pop_d.size;
        dctl_reg <= pop_d.ctrl; moved_reg <= '0; cur_reg <= pop_d.idx;
        peer_ptr_o <= pop_d.ctrl[drdc_pkg::DC_DSTV] ? pop_d.dst : pop_d.src;
      end
      if (state_reg == drdc_pkg::ST_REQ && !uppeer_reg && !rd_valid && !free_all) begin
        rd_valid <= 1'b1; rd_addr <= src_reg; rd_len <= chunk; chunk_reg <= chunk;
      end
      if (rd_valid && (rd_ready || free_all)) rd_valid <= 1'b0;
      // completion data becomes posted write data
      if (state_reg == drdc_pkg::ST_CPL && cpl_valid && !free_all) begin
        wr_valid <= 1'b1; wr_addr <= dst_reg; wr_data <= cpl_data; wr_last <= cpl_last;
        if (cpl_last) begin
          src_reg   <= src_reg + 64'(chunk_reg);
          dst_reg   <= dst_reg + 64'(chunk_reg);
          rem_reg   <= rem_reg - 24'(chunk_reg);
          moved_reg <= moved_reg + 24'(chunk_reg);
        end
      end
      if (fin) begin
        desc_irq   <= dctl_reg[drdc_pkg::DC_IRQ];
        // bridge side also advances the peer; each side advances its own ring
        peer_adv_o <= bridge_reg;
        cur_reg    <= (cnext >= ring_reg) ? 5'h00 : cnext[4:0];
        if (is_final) xcnt_reg <= moved_reg;
        if (uppeer_reg && pfin_reg) xcnt_reg <= pcnt_reg;
        // bridge reports final and count to peer
        if (bridge_reg && is_final) begin
          peer_final_o <= 1'b1;
          peer_count_o <= moved_reg;
        end
        // engine writes final flag and count
        if (need_wb) begin
          dwb_addr <= base_reg + 64'(cur_reg) * 64'(dbyte) + soff;
          dwb_size <= uppeer_reg ? pcnt_reg : moved_reg;
          dwb_ctrl <= dctl_reg | (8'h01 << drdc_pkg::DC_FINAL);
        end
      end
      if (state_next == drdc_pkg::ST_WB && state_reg != drdc_pkg::ST_WB) dwb_valid <= 1'b1;
      if (state_reg == drdc_pkg::ST_IDLE && state_next == drdc_pkg::ST_WB) begin
        dwb_addr <= base_reg + 64'(cur_reg) * 64'(dbyte) + soff;
        dwb_size <= pcnt_reg;
        dwb_ctrl <= dctl_reg | (8'h01 << drdc_pkg::DC_FINAL);
      end
      if (dwb_valid && dwb_ready) begin
        dwb_valid <= 1'b0;
        pfin_reg  <= 1'b0;
      end
      if (stop_evt) begin
        cur_reg   <= '0;
        pfin_reg  <= 1'b0;
        dwb_valid <= 1'b0;
      end
    end
  end

endmodule

//--- test/drdc_channel_assertions.sv
`timescale 1ns/10ps
module drdc_channel_assertions (
  // Clock, reset, bus, events
  input wire logic        clk_sys, reset, wb_cyc_i, wb_stb_i, wb_ack_o, halt_irq,
  // Handshakes
  input wire logic        dreq_valid, dreq_ready, rd_valid, rd_ready, dwb_valid, rd_flush,
  // Payloads
  input wire logic [63:0] dreq_addr, rd_addr,
  input wire logic [5:0]  dreq_cnt,
  input wire logic [12:0] rd_len,
  input wire logic [7:0]  dwb_ctrl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence fetch_wait_s; dreq_valid && !dreq_ready; endsequence
  sequence read_wait_s; rd_valid && !rd_ready; endsequence
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  fetch_hold_a: assert property (fetch_wait_s |=> dreq_valid && $stable(dreq_addr))
    else $error("fetch request changed before ready");
  fetch_count_a: assert property (dreq_valid |-> dreq_cnt inside {[1:12]})
    else $error("fetch count outside fifo room");
  read_hold_a: assert property (read_wait_s |=> rd_flush || rd_valid && $stable(rd_len))
    else $error("read request changed before ready");
  read_page_a: assert property (rd_valid |-> rd_len != 0 &&
    14'(rd_addr[11:0]) + 14'(rd_len) <= 14'h1000) else $error("read crosses page");
  wb_final_a: assert property (dwb_valid |-> dwb_ctrl[7])
    else $error("write-back without final flag");
  halt_pulse_a: assert property (halt_irq |=> !halt_irq)
    else $error("halt event longer than a pulse");
endmodule
bind drdc_channel drdc_channel_assertions u_chk (.*);

//--- test/drdc_far_model.sv
`timescale 1ns/10ps
module drdc_far_model (
  // Clock, reset, pacing
  input  wire logic        clk_sys, reset, slow,
  // Descriptor fetch, data read and write-back requests
  input  wire logic        dreq_valid, rd_valid, dwb_valid,
  input  wire logic [63:0] dreq_addr, rd_addr,
  input  wire logic [5:0]  dreq_cnt,
  input  wire logic [12:0] rd_len,
  // Answers
  output logic             dreq_ready, drx_valid, rd_ready, cpl_valid, cpl_last, dwb_ready,
  output logic      [63:0] drx_src, drx_dst,
  output logic      [23:0] drx_size,
  output logic      [7:0]  drx_ctrl,
  output logic      [31:0] cpl_data
);
  logic [31:0] i, a;
  logic [12:0] k;
  initial {dreq_ready, drx_valid, rd_ready, cpl_valid, cpl_last, dwb_ready} = '0;
  initial {drx_src, drx_dst, drx_size, drx_ctrl, cpl_data} = '0;
  // Ring of 12-byte entries at zero, the last one final
  initial forever begin
    @(posedge clk_sys);
    if (dreq_valid && !reset) begin
      repeat (slow ? 3 : 0) @(posedge clk_sys);
      dreq_ready <= 1'b1;
      i = dreq_addr[31:0] / 12;
      @(posedge clk_sys);
      dreq_ready <= 1'b0;
      repeat (dreq_cnt) begin
        @(posedge clk_sys);
        drx_valid <= 1'b1;
        drx_src <= {32'h0, i << 6};
        drx_dst <= {32'h0, 32'h10000 + (i << 6)};
        drx_size <= 24'h8;
        drx_ctrl <= {1'(i == 31), 7'h40};
        i = i + 1;
      end
      @(posedge clk_sys);
      drx_valid <= 1'b0;
      drx_src <= ~drx_src;
    end
  end
  // Completion data echoes the read address
  initial forever begin
    @(posedge clk_sys);
    if (rd_valid && !reset) begin
      repeat (slow ? 2 : 0) @(posedge clk_sys);
      rd_ready <= 1'b1;
      a = rd_addr[31:0];
      k = rd_len >> 2;
      @(posedge clk_sys);
      rd_ready <= 1'b0;
      for (int j = 1; j <= k; j++) begin
        @(posedge clk_sys);
        cpl_valid <= 1'b1;
        cpl_data <= a;
        cpl_last <= (j == k);
        a = a + 4;
      end
      @(posedge clk_sys);
      {cpl_valid, cpl_last, cpl_data} <= {2'b00, ~a};
    end
  end
  always @(posedge clk_sys) dwb_ready <= dwb_valid && !dwb_ready && !slow;
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys, reset, slow, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dreq_valid, dreq_ready;
  logic drx_valid, rd_valid, rd_ready, rd_flush, cpl_valid, cpl_last, wr_valid, wr_last;
  logic dwb_valid, dwb_ready, peer_adv_o, peer_adv_i, peer_final_o, peer_final_i;
  logic desc_irq, halt_irq;
  logic [7:0] wb_adr_i, drx_ctrl, dwb_ctrl;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, cpl_data, wr_data, seed, pf;
  logic [63:0] dreq_addr, drx_src, drx_dst, rd_addr, wr_addr, dwb_addr, peer_ptr_o, peer_ptr_i;
  logic [5:0] dreq_cnt;
  logic [12:0] rd_len;
  logic [23:0] drx_size, dwb_size, peer_count_o, peer_count_i;
  logic [95:0] exp_wr[$];
  logic [31:0] exp_rd[$];
  int fail_count, total_checks, irqs, halts, dwbs, cycles, flushes;
  drdc_channel DUT (.*);
  drdc_far_model far (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic compare(input logic [95:0] e, input logic [95:0] g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Watcher: results against the oldest note
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    {seed, slow} <= {xs(seed), seed[0]};
    if (wb_ack_o === 1'b1 && !wb_we_i) compare(exp_rd.pop_front(), wb_dat_o);
    if (wr_valid === 1'b1) compare(exp_wr.size() ? exp_wr.pop_front() : 'x, {wr_addr, wr_data});
    irqs <= irqs + (desc_irq === 1'b1);
    halts <= halts + (halt_irq === 1'b1);
    dwbs <= dwbs + (dwb_valid && dwb_ready);
    flushes <= flushes + (rd_flush === 1'b1);
    if (dwb_valid === 1'b1 && dwb_ready === 1'b1)
      compare({64'h17C, 24'h8, 8'hC0}, {dwb_addr, dwb_size, dwb_ctrl});
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, slow} = '0;
    {peer_ptr_i, peer_adv_i, peer_final_i, peer_count_i} = '0;
    {seed, reset} = {32'hF4D8, 1'b1};
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h0C, 32'h20);
    rd(8'h20, 32'h00800200);
    rd(8'h24, 32'h0);
    pf = seed % 32 + 1;
    wb(1'b1, 8'h10, pf);
    rd(8'h10, pf);
    $display("test done: registers");
    for (int i = 0; i < 32; i++)
      for (int j = 0; j < 2; j++)
        exp_wr.push_back({32'h0, 32'h10000 + 32'(i) * 64, 32'(i) * 64 + 4 * j});
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b1, 8'h00, 32'h1);
    while (irqs < 32 || dwbs < 1 || exp_wr.size()) @(posedge clk_sys);
    compare(32, irqs);
    rd(8'h1C, 32'h8);
    rd(8'h14, 32'h0);
    $display("test done: ring transfer");
    wb(1'b1, 8'h00, 32'h3);
    while (halts < 1) @(posedge clk_sys);
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'hFFFFFFFF);
    rd(8'h00, 32'h503);
    wb(1'b1, 8'h00, 32'h101);
    rd(8'h14, 32'hFFFFFFFF);
    rd(8'h00, 32'h501);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    compare(1, halts);
    $display("test done: halt and stop");
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b1, 8'h00, 32'h5);
    rd(8'h14, 32'h0);
    rd(8'h00, 32'h605);
    wb(1'b1, 8'h00, 32'h1);
    rd(8'h00, 32'h1);
    compare(2, flushes);
    $display("test done: cancel");
    end_of_test();
  end
endmodule
